// >>> verilog/agcreg_map.svh
// Offsets, field positions, reset values and limits of the AGC control slice.
// Assumes a page-0 byte address of eight bits supplied by the host port.
`ifndef AGCREG_MAP_SVH
`define AGCREG_MAP_SVH

`define AGCREG_LEFT_GAIN_OFS 8'h5D
`define AGCREG_RIGHT_ENTGT_OFS 8'h5E
`define AGCREG_RIGHT_HYSTNS_OFS 8'h5F
`define AGCREG_RIGHT_MAXG_OFS 8'h60

`define AGCREG_EN_BIT 7
`define AGCREG_TGT_HI 6
`define AGCREG_TGT_LO 4
`define AGCREG_GHYST_HI 1
`define AGCREG_GHYST_LO 0
`define AGCREG_HYST_HI 7
`define AGCREG_HYST_LO 6
`define AGCREG_NOISE_HI 5
`define AGCREG_NOISE_LO 1
`define AGCREG_MAXG_HI 6
`define AGCREG_MAXG_LO 0

`define AGCREG_GAIN_RST 8'h00
`define AGCREG_GAIN_MIN 8'hE8
`define AGCREG_GAIN_MAX 8'h74
`define AGCREG_MAXG_RST 7'h7F
`define AGCREG_MAXG_TOP 7'h74
`define AGCREG_HYST_OFF 2'h3
`define AGCREG_NOISE_OFF 5'h00

`endif

// >>> verilog/agcreg_pkg.sv
// Types shared by the AGC control slice and its users.
// Assumes agcreg_map.svh is on the include path.
package agcreg_pkg;

   // Raw right-channel control fields as software programmed them.
   typedef struct packed {
      logic enable;
      logic [2:0] target;
      logic [1:0] gain_hyst;
      logic [1:0] hyst;
      logic [4:0] noise;
      logic [6:0] max_gain;
   } agcreg_rctl_s;

   // Decoded settings for the right AGC loop: levels in signed or unsigned steps, plus the hyst_off and noise_gate_on flags.
   typedef struct packed {
      logic signed [7:0] target_half_db;
      logic [1:0] gain_hyst_half_db;
      logic [3:0] hyst_half_db;
      logic hyst_off;
      logic noise_gate_on;
      logic signed [7:0] noise_db;
      logic [6:0] max_gain_half_db;
   } agcreg_rlvl_s;

endpackage

// >>> verilog/agcreg_gain_track.sv
// Holds the left-channel applied-gain readout, following the AGC loop.
// Assumes the loop's gain word and strobe come from logic on the same clock.
`timescale 1ns/1ns
`include "agcreg_map.svh"

module agcreg_gain_track
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Gain reported by the loop
   input wire logic gain_valid,
   input wire logic [7:0] gain_in,
   // Readout
   output logic [7:0] gain
);
   import agcreg_pkg::*;

   // A loop glitch outside the printed span must never show as an illegal code.
   function automatic logic [7:0] clamp_gain(input logic [7:0] g);
      if ($signed(g) < $signed(`AGCREG_GAIN_MIN))
         clamp_gain = `AGCREG_GAIN_MIN;
      else if ($signed(g) > $signed(`AGCREG_GAIN_MAX))
         clamp_gain = `AGCREG_GAIN_MAX;
      else
         clamp_gain = g;
   endfunction

   wire logic [7:0] next_gain = gain_valid ? clamp_gain(gain_in) : gain;

   // (R1) (R2) (R12) clamped tracking, zero reset
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         gain <= `AGCREG_GAIN_RST;
      else
         gain <= next_gain;
   end

   // (R1) readout range
   AST_GAIN_RANGE: assert property (@(posedge clk) disable iff (!rst_n) // (R1)
      $signed(gain) >= $signed(`AGCREG_GAIN_MIN) && $signed(gain) <= $signed(`AGCREG_GAIN_MAX))
      else $error("Left gain readout outside -12.0 to 58.0 dB.");

   // (R12) tracking the loop
   AST_GAIN_TRACK: assert property (@(posedge clk) disable iff (!rst_n) // (R12)
      gain_valid && $signed(gain_in) >= -24 && $signed(gain_in) <= 116
      |=> gain == $past(gain_in))
      else $error("Left gain readout did not follow the loop.");

endmodule

// >>> verilog/agcreg_top.sv
// AGC control register slice: left applied-gain readout and right-channel
// enable, target, hysteresis, noise gate and maximum-gain settings.
// Assumes a host port on clk with one-cycle strobes and page 0 selected.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`include "agcreg_map.svh"

// Function
// (R1) Left applied gain reads as 8-bit two's complement, -12.0 to 58.0 dB.
// (R2) Left gain readout is zero, meaning 0.0 dB, after reset.
// (R3) Bit 7 of the first right register enables the right AGC; resets 0.
// (R4) Bits 6:4 choose the right target level, -5.5 down to -24.0 dBFS.
// (R5) Bits 1:0 set gain hysteresis: off, 0.5, 1.0, 1.5 dB.
// (R6) Second register bits 7:6 select 1, 2, 4 dB hysteresis, or off.
// (R7) Noise code zero disables the gate; code n sets -(28+2n) dB.
// (R8) Third register bits 6:0 limit gain to code times 0.5 dB.
// (R9) Codes above 116 are discouraged and still limit gain to 58.0 dB.
// (R10) Maximum-gain field resets to 127, treated as the 58.0 dB ceiling.
// (R11) Host writes zero to reserved bits; device reads them as zero.
// (R12) Readout follows the loop's applied gain; writes to it do nothing.
module agcreg_top
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Host register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // Left AGC loop status
   input wire logic left_gain_valid,
   input wire logic [7:0] left_gain_in,
   // Right AGC loop settings
   output agcreg_pkg::agcreg_rctl_s right_ctl,
   output agcreg_pkg::agcreg_rlvl_s right_lvl
);
   import agcreg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release

   logic rst_meta;
   logic rst_n;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   function automatic logic signed [7:0] target_half_db(input logic [2:0] code);
      unique case (code)
         3'h0: target_half_db = -8'sd11;
         3'h1: target_half_db = -8'sd16;
         3'h2: target_half_db = -8'sd20;
         3'h3: target_half_db = -8'sd24;
         3'h4: target_half_db = -8'sd28;
         3'h5: target_half_db = -8'sd34;
         3'h6: target_half_db = -8'sd40;
         3'h7: target_half_db = -8'sd48;
      endcase
   endfunction

   function automatic logic signed [7:0] noise_db(input logic [4:0] code);
      noise_db = -8'sd28 - $signed({2'h0, code, 1'b0});
   endfunction

   function automatic logic [6:0] max_gain_eff(input logic [6:0] code);
      max_gain_eff = (code > `AGCREG_MAXG_TOP) ? `AGCREG_MAXG_TOP : code;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   wire logic sel_gain = addr == `AGCREG_LEFT_GAIN_OFS;
   wire logic sel_entgt = addr == `AGCREG_RIGHT_ENTGT_OFS;
   wire logic sel_hystns = addr == `AGCREG_RIGHT_HYSTNS_OFS;
   wire logic sel_maxg = addr == `AGCREG_RIGHT_MAXG_OFS;

   wire logic wr_entgt = wr && sel_entgt;
   wire logic wr_hystns = wr && sel_hystns;
   wire logic wr_maxg = wr && sel_maxg;

   ////////////////////////////////////////////////////////////////////////////
   // Left gain readout

   logic [7:0] left_gain;

   agcreg_gain_track agcreg_gain_track_i
   (
      .clk(clk),
      .rst_n(rst_n),
      .gain_valid(left_gain_valid),
      .gain_in(left_gain_in),
      .gain(left_gain)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Right-channel control registers

   agcreg_rctl_s ctl;

   // (R3) (R4) (R5) first register fields
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctl.enable <= 1'b0;
         ctl.target <= 3'h0;
         ctl.gain_hyst <= 2'h0;
      end
      else if (wr_entgt)
      begin
         ctl.enable <= wdata[`AGCREG_EN_BIT];
         ctl.target <= wdata[`AGCREG_TGT_HI:`AGCREG_TGT_LO];
         ctl.gain_hyst <= wdata[`AGCREG_GHYST_HI:`AGCREG_GHYST_LO];
      end
   end

   // (R6) (R7) second register fields
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctl.hyst <= 2'h0;
         ctl.noise <= `AGCREG_NOISE_OFF;
      end
      else if (wr_hystns)
      begin
         ctl.hyst <= wdata[`AGCREG_HYST_HI:`AGCREG_HYST_LO];
         ctl.noise <= wdata[`AGCREG_NOISE_HI:`AGCREG_NOISE_LO];
      end
   end

   // (R8) (R10) maximum gain, all ones at reset
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ctl.max_gain <= `AGCREG_MAXG_RST;
      else if (wr_maxg)
         ctl.max_gain <= wdata[`AGCREG_MAXG_HI:`AGCREG_MAXG_LO];
   end

   assign right_ctl = ctl;

   ////////////////////////////////////////////////////////////////////////////
   // Decoded settings for the loop

   // (R4) target level decode
   assign right_lvl.target_half_db = target_half_db(ctl.target);
   // (R5) gain hysteresis in half-dB steps
   assign right_lvl.gain_hyst_half_db = ctl.gain_hyst;
   // (R6) hysteresis decode
   assign right_lvl.hyst_off = ctl.hyst == `AGCREG_HYST_OFF;
   assign right_lvl.hyst_half_db = right_lvl.hyst_off ? 4'h0 : 4'h2 << ctl.hyst;
   // (R7) noise gate decode
   assign right_lvl.noise_gate_on = ctl.noise != `AGCREG_NOISE_OFF;
   assign right_lvl.noise_db = right_lvl.noise_gate_on ? noise_db(ctl.noise) : 8'sh00;
   // (R9) ceiling for discouraged codes
   assign right_lvl.max_gain_half_db = max_gain_eff(ctl.max_gain);

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   // Reserved bits are rebuilt as zero rather than stored, so a careless
   // write can never make them read back nonzero.
   wire logic [7:0] rd_entgt = {ctl.enable, ctl.target, 2'h0, ctl.gain_hyst};
   wire logic [7:0] rd_hystns = {ctl.hyst, ctl.noise, 1'b0};
   wire logic [7:0] rd_maxg = {1'b0, ctl.max_gain};

   // (R11) reserved bits read zero
   wire logic [7:0] rd_mux = sel_gain ? left_gain :
                             sel_entgt ? rd_entgt :
                             sel_hystns ? rd_hystns :
                             sel_maxg ? rd_maxg : 8'h00;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= 8'h00;
      else
         rdata <= rd ? rd_mux : 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   AST_GAIN_RESET: assert property ($rose(rst_n) |-> left_gain == 8'h00) // (R2)
      else $error("Left gain readout not zero after reset.");

   AST_GAIN_READ: assert property (rd && sel_gain |=> rdata == $past(left_gain)) // (R1)
      else $error("Gain read does not return the readout.");

   AST_RO_WRITE: assert property ( // (R12)
      wr && sel_gain && !left_gain_valid |=> $stable(left_gain))
      else $error("Write changed the read-only gain readout.");

   AST_ENABLE: assert property (wr_entgt |=> right_ctl.enable == $past(wdata[7])) // (R3)
      else $error("Enable bit did not take the written value.");

   AST_TARGET: assert property ( // (R4)
      wr_entgt && wdata[6:4] == 3'h5 |=> right_lvl.target_half_db == -8'sd34)
      else $error("Target code 5 not decoded as -17.0 dBFS.");

   AST_GHYST: assert property ( // (R5)
      wr_entgt ##1 rd && sel_entgt |=> rdata[1:0] == right_lvl.gain_hyst_half_db)
      else $error("Gain hysteresis readback mismatch.");

   AST_HYST: assert property ( // (R6)
      wr_hystns |=> right_lvl.hyst_off == ($past(wdata[7:6]) == 2'h3)
      && (right_lvl.hyst_off || right_lvl.hyst_half_db == 4'h2 << $past(wdata[7:6])))
      else $error("Hysteresis setting decoded wrongly.");

   AST_NOISE: assert property ( // (R7)
      wr_hystns && wdata[5:1] == 5'h1F |=> right_lvl.noise_gate_on
      && right_lvl.noise_db == -8'sd90)
      else $error("Noise code 31 not decoded as -90 dB.");

   AST_NOISE_OFF: assert property ( // (R7)
      wr_hystns && wdata[5:1] == 5'h00 |=> !right_lvl.noise_gate_on)
      else $error("Noise gate still on at code zero.");

   AST_MAXG: assert property ( // (R8)
      wr_maxg && wdata[6:0] <= 7'h74 |=> right_lvl.max_gain_half_db == $past(wdata[6:0]))
      else $error("Maximum gain not applied as written.");

   AST_MAXG_CLIP: assert property ( // (R9)
      right_ctl.max_gain > 7'h74 |-> right_lvl.max_gain_half_db == 7'h74)
      else $error("Discouraged maximum-gain code not limited to 58.0 dB.");

   AST_MAXG_RESET: assert property ( // (R10)
      $rose(rst_n) |-> right_ctl.max_gain == 7'h7F && right_lvl.max_gain_half_db == 7'h74)
      else $error("Maximum gain not at its reset ceiling.");

   AST_RSVD: assert property (rd && sel_entgt |=> rdata[3:2] == 2'h0) // (R11)
      else $error("Reserved bits of the first right register read nonzero.");

   AST_RSVD_HYSTNS: assert property (rd && sel_hystns |=> rdata[0] == 1'b0) // (R11)
      else $error("Reserved bit of the second right register read nonzero.");

   AST_RSVD_MAXG: assert property (rd && sel_maxg |=> rdata[7] == 1'b0) // (R11)
      else $error("Reserved bit of the third right register read nonzero.");

   AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00)
      else $error("Read data present without a read.");

   COV_ENABLE: cover property (wr_entgt && wdata[7] ##1 right_ctl.enable);
   COV_MAXG_CLIP: cover property (wr_maxg && wdata[6:0] == 7'h7F);
   COV_GAIN_NEG: cover property (left_gain_valid && left_gain_in == 8'hE8 ##1 rd && sel_gain);
   COV_NOISE: cover property (wr_hystns && wdata[5:1] == 5'h01);

endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the AGC control register slice.
// Assumes agcreg_pkg is compiled first and agcreg_map.svh is on the include path.
`timescale 1ns/1ns

module tb_top;
   import agcreg_pkg::*;

   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic left_gain_valid = 1'b0;
   logic [7:0] left_gain_in = 8'h00;
   agcreg_rctl_s right_ctl;
   agcreg_rlvl_s right_lvl;
   int mismatches = 0;
   int tests_run = 0;

   always #4 clk = ~clk;

   agcreg_top agcreg_top_i (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .left_gain_valid(left_gain_valid),
      .left_gain_in(left_gain_in), .right_ctl(right_ctl), .right_lvl(right_lvl));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One-cycle write; settings are looked at in the cycle after the strobe.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(negedge clk);
   endtask

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk("rdata", exp, rdata);
   endtask

   task automatic load_gain(input logic [7:0] g, input logic [7:0] exp);
      @(posedge clk);
      left_gain_valid <= 1'b1;
      left_gain_in <= g;
      @(posedge clk);
      left_gain_valid <= 1'b0;
      rd_chk(8'h5D, exp);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_reset;
      rd_chk(8'h5D, 8'h00);
      rd_chk(8'h5E, 8'h00);
      rd_chk(8'h5F, 8'h00);
      rd_chk(8'h60, 8'h7F);
      chk("max_gain_half_db", 8'h74, {1'b0, right_lvl.max_gain_half_db});
      chk("noise_gate_on", 8'h00, {7'h00, right_lvl.noise_gate_on});
   endtask

   task automatic test_enable_target;
      logic [7:0] tt[8] = '{8'hF5, 8'hF0, 8'hEC, 8'hE8, 8'hE4, 8'hDE, 8'hD8, 8'hD0};
      for (int i = 0; i < 8; i++)
      begin
         wr_reg(8'h5E, {1'b1, 3'(i), 2'b00, 2'(i)});
         chk("target_half_db", tt[i], right_lvl.target_half_db);
         chk("gain_hyst", {6'h00, 2'(i)}, {6'h00, right_lvl.gain_hyst_half_db});
         chk("enable", 8'h01, {7'h00, right_ctl.enable});
      end
      wr_reg(8'h5E, 8'hFF);
      rd_chk(8'h5E, 8'hF3);
      wr_reg(8'h5E, 8'h00);
      chk("enable", 8'h00, {7'h00, right_ctl.enable});
   endtask

   task automatic test_hyst_noise;
      logic [7:0] hh[4] = '{8'h02, 8'h04, 8'h08, 8'h00};
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(8'h5F, {2'(i), 6'h00});
         chk("hyst_half_db", hh[i], {4'h0, right_lvl.hyst_half_db});
         chk("hyst_off", {7'h00, i == 3}, {7'h00, right_lvl.hyst_off});
      end
      wr_reg(8'h5F, 8'h02);
      chk("noise_db n1", 8'hE2, right_lvl.noise_db);
      chk("noise_gate_on", 8'h01, {7'h00, right_lvl.noise_gate_on});
      wr_reg(8'h5F, 8'h3F);
      chk("noise_db n31", 8'hA6, right_lvl.noise_db);
      rd_chk(8'h5F, 8'h3E);
      wr_reg(8'h5F, 8'hFF);
      rd_chk(8'h5F, 8'hFE);
   endtask

   task automatic test_max_gain;
      logic [7:0] cc[5] = '{8'h00, 8'h01, 8'h74, 8'h75, 8'hFF};
      logic [7:0] ee[5] = '{8'h00, 8'h01, 8'h74, 8'h74, 8'h74};
      for (int i = 0; i < 5; i++)
      begin
         wr_reg(8'h60, cc[i]);
         chk("max_gain_half_db", ee[i], {1'b0, right_lvl.max_gain_half_db});
         rd_chk(8'h60, {1'b0, cc[i][6:0]});
      end
   endtask

   task automatic test_left_gain;
      load_gain(8'h10, 8'h10);
      load_gain(8'hE8, 8'hE8);
      load_gain(8'h74, 8'h74);
      load_gain(8'h80, 8'hE8);
      load_gain(8'h75, 8'h74);
      wr_reg(8'h5D, 8'h33);
      rd_chk(8'h61, 8'h00);
      rd_chk(8'h5D, 8'h74);
      @(negedge clk);
      chk("rdata idle", 8'h00, rdata);
   endtask

   // Reset in mid-run must bring back the readout and the ceiling.
   task automatic test_mid_reset;
      wr_reg(8'h60, 8'h10);
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(8'h5D, 8'h00);
      rd_chk(8'h60, 8'h7F);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // A hang is cut short well after the 115 or so cycles the tests need.
   initial
   begin
      #200000;
      mismatches++;
      give_verdict();
   end

   initial
   begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      test_reset();
      test_enable_target();
      test_hyst_noise();
      test_max_gain();
      test_left_gain();
      test_mid_reset();
      give_verdict();
   end
endmodule
